// [hw/flash_check_pkg.sv]
package flash_check_pkg;

   // Flash word and address widths
   localparam int ADDR_W = 16;
   localparam int DATA_W = 16;

   // Default flash map, in words
   localparam logic [ADDR_W-1:0] PROG_BASE   = 16'h0000;
   localparam logic [ADDR_W-1:0] PROG_LEN    = 16'h0400;
   localparam logic [ADDR_W-1:0] REF_BASE    = 16'h03c0;
   localparam logic [ADDR_W-1:0] COEF_BASE   = 16'h0400;
   localparam logic [ADDR_W-1:0] COEF_LEN    = 16'h0040;
   localparam logic [ADDR_W-1:0] CAL_BASE    = 16'h0440;
   localparam logic [ADDR_W-1:0] CAL_LEN     = 16'h0040;
   localparam logic [ADDR_W-1:0] UNUSED_BASE = 16'h0480;
   localparam logic [ADDR_W-1:0] UNUSED_LEN  = 16'h0b80;

   // APB register byte offsets
   localparam logic [11:0] RESULT_OFS  = 12'h000;
   localparam logic [11:0] IRQ_STS_OFS = 12'h004;
   localparam logic [11:0] IRQ_CLR_OFS = 12'h008;
   localparam logic [11:0] IRQ_EN_OFS  = 12'h00c;
   localparam logic [11:0] MODE_OFS    = 12'h010;

   // Interrupt bit positions
   localparam int IRQ_DONE  = 0;
   localparam int IRQ_ERR   = 1;
   localparam int IRQ_FIX   = 2;
   localparam int IRQ_W     = 3;

   // Status byte field positions
   localparam int ST_SAT    = 0;
   localparam int ST_CODE   = 1;
   localparam int ST_AUX    = 3;
   localparam int ST_ERR    = 4;
   localparam int ST_ZERO   = 5;
   localparam int ST_LSB    = 6;

   // Failure codes carried in status bits 2:1
   localparam logic [1:0] CODE_PROG   = 2'h1;
   localparam logic [1:0] CODE_CAL    = 2'h3;
   localparam logic [1:0] CODE_COEF   = 2'h2;
   localparam logic [1:0] CODE_UNUSED = 2'h0;

   // Values after reset
   localparam logic [1:0]  MODE_RESET   = 2'h0;
   localparam logic [7:0]  STATUS_RESET = 8'h00;

   typedef enum logic [3:0] {
      S_PROG, S_PROG_END, S_COEF_REF, S_COEF_CUR, S_COEF_WR,
      S_CAL, S_CAL_END, S_UNUSED, S_DONE
   } check_state_e;

endpackage : flash_check_pkg

// [hw/sum_if.sv]
`timescale 1ns/100ps
// Running checksum link between sequencer and accumulator
interface sum_if;
   import flash_check_pkg::*;
   logic              clr;
   logic              add;
   logic [DATA_W-1:0] data;
   logic              zero;

   modport seq (output clr, output add, output data, input zero);
   modport acc (input clr, input add, input data, output zero);
endinterface : sum_if

// [hw/checksum_acc.sv]
`timescale 1ns/100ps
// Word-wide modular sum; an area passes when its sum is zero
module checksum_acc
   import flash_check_pkg::*;
(
   input  wire logic clk,
   input  wire logic srst,
   sum_if.acc        s
);
   logic [DATA_W-1:0] sum_reg;
   logic [DATA_W-1:0] sum_next;

   // Clear wins over add so a new area starts clean
   assign sum_next = s.clr ? '0 : (s.add ? sum_reg + s.data : sum_reg);
   assign s.zero   = (sum_reg == '0);

   always_ff @(posedge clk) begin
      if (srst) begin
         sum_reg <= '0;
      end else begin
         sum_reg <= sum_next;
      end
   end
endmodule : checksum_acc

// [hw/flash_startup_check.sv]
`timescale 1ns/100ps
// How it works
// - Errors are flagged in the status byte; measurement output keeps going.
// - Each startup sums program, calibration areas; checks coefficient area if program passes.
// - Unused flash is scanned; any word not all ones is reported.
// - Coefficients compared to reference only after the program sum passes.
// - Mismatching coefficient words are rewritten from the reference copy.
// - Calibration sum checked after coefficients; its code overrides mismatch.
// - Any of the four failures sets status bit 4.
// - Codes in bits 2:1: program 01, cal 11, coef 10, unused 00.
// - Only highest priority failure is shown: program, cal, coef, unused.
// - Refresh happens despite a cal failure, never after a program failure.
// - With bit 4 clear, bits 2:1 show the active data modes.
// - Bits 7:6 carry measurement LSBs, bit 0 the saturation flag.
module flash_startup_check
   import flash_check_pkg::*;
#(
   parameter logic [ADDR_W-1:0] P_PROG_BASE   = PROG_BASE,
   parameter logic [ADDR_W-1:0] P_PROG_LEN    = PROG_LEN,
   parameter logic [ADDR_W-1:0] P_REF_BASE    = REF_BASE,
   parameter logic [ADDR_W-1:0] P_COEF_BASE   = COEF_BASE,
   parameter logic [ADDR_W-1:0] P_COEF_LEN    = COEF_LEN,
   parameter logic [ADDR_W-1:0] P_CAL_BASE    = CAL_BASE,
   parameter logic [ADDR_W-1:0] P_CAL_LEN     = CAL_LEN,
   parameter logic [ADDR_W-1:0] P_UNUSED_BASE = UNUSED_BASE,
   parameter logic [ADDR_W-1:0] P_UNUSED_LEN  = UNUSED_LEN
)(
   input  wire logic                                  clk,
   input  wire logic                                  srst,
   // APB slave
   input  wire logic                                  psel,
   input  wire logic                                  penable,
   input  wire logic                                  pwrite,
   input  wire logic [11:0]                           paddr,
   input  wire logic [31:0]                           pwdata,
   output logic      [31:0]                           prdata,
   output logic                                       pready,
   output logic                                       pslverr,
   output logic                                       irq,
   // Flash word port, one request outstanding
   output logic                                       flash_req,
   output logic                                       flash_we,
   output logic      [flash_check_pkg::ADDR_W-1:0]    flash_addr,
   output logic      [flash_check_pkg::DATA_W-1:0]    flash_wdata,
   input  wire logic                                  flash_ack,
   input  wire logic [flash_check_pkg::DATA_W-1:0]    flash_rdata,
   // Packet status byte assembly
   input  wire logic [1:0]                            meas_lsbs,
   input  wire logic                                  saturated,
   input  wire logic                                  aux_flag,
   output logic      [7:0]                            packet_status_byte,
   output logic                                       tx_enable
);
   // Reference copy must sit inside the program area it is covered by
   if (P_REF_BASE < P_PROG_BASE ||
       P_REF_BASE + P_COEF_LEN > P_PROG_BASE + P_PROG_LEN ||
       P_PROG_LEN == '0 || P_COEF_LEN == '0 || P_CAL_LEN == '0 ||
       P_UNUSED_LEN == '0) begin : g_map_check
      $error("flash map parameters are inconsistent");
   end

   check_state_e      state_reg, state_next;
   logic [ADDR_W-1:0] idx_reg;
   logic [DATA_W-1:0] ref_reg;
   logic              req_reg, we_reg;
   logic [ADDR_W-1:0] addr_reg;
   logic [DATA_W-1:0] wdata_reg;
   logic              prog_bad_reg, cal_bad_reg, coef_bad_reg, blank_bad_reg;
   logic              done_reg;
   logic              err_reg;
   logic [1:0]        code_reg;
   logic [1:0]        mode_reg;
   logic [IRQ_W-1:0]  irq_sts_reg, irq_en_reg;
   logic [7:0]        status_reg;
   logic [31:0]       prdata_reg;
   logic              pready_reg, pslverr_reg, irq_reg;

   sum_if s ();

   checksum_acc u_acc (
      .clk  (clk),
      .srst (srst),
      .s    (s)
   );

   // Sequencer view of the current access
   logic              got;
   logic              last_prog, last_coef, last_cal, last_unused;
   logic              is_access;
   logic [ADDR_W-1:0] idx_inc;
   logic              any_err;
   logic [1:0]        code_next;

   assign got         = req_reg & flash_ack;
   assign idx_inc     = idx_reg + 1'b1;
   assign last_prog   = (idx_inc == P_PROG_LEN);
   assign last_coef   = (idx_inc == P_COEF_LEN);
   assign last_cal    = (idx_inc == P_CAL_LEN);
   assign last_unused = (idx_inc == P_UNUSED_LEN);
   assign is_access   = (state_reg == S_PROG) || (state_reg == S_COEF_REF) ||
                        (state_reg == S_COEF_CUR) || (state_reg == S_COEF_WR) ||
                        (state_reg == S_CAL) || (state_reg == S_UNUSED);

   // Summed areas feed the accumulator straight from the read data
   assign s.add  = got & ((state_reg == S_PROG) || (state_reg == S_CAL));
   assign s.data = flash_rdata;
   assign s.clr  = (state_reg == S_PROG_END) || (state_reg == S_CAL_END);

   // Area order: program, coefficients, calibration, unused
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         S_PROG: begin
            if (got && last_prog) state_next = S_PROG_END;
         end
         S_PROG_END: begin
            // Coefficients are trusted only against a good reference
            state_next = s.zero ? S_COEF_REF : S_CAL;
         end
         S_COEF_REF: begin
            if (got) state_next = S_COEF_CUR;
         end
         S_COEF_CUR: begin
            if (got && flash_rdata != ref_reg) begin
               state_next = S_COEF_WR;
            end else if (got) begin
               state_next = last_coef ? S_CAL : S_COEF_REF;
            end
         end
         S_COEF_WR: begin
            if (got) state_next = last_coef ? S_CAL : S_COEF_REF;
         end
         S_CAL: begin
            if (got && last_cal) state_next = S_CAL_END;
         end
         S_CAL_END: begin
            state_next = S_UNUSED;
         end
         S_UNUSED: begin
            if (got && last_unused) state_next = S_DONE;
         end
         S_DONE: begin
            state_next = S_DONE;
         end
         default: begin
            state_next = S_PROG;
         end
      endcase
   end

   // Address of the next flash access in each phase
   logic [ADDR_W-1:0] addr_next;
   assign addr_next =
      (state_reg == S_PROG)     ? P_PROG_BASE + idx_reg :
      (state_reg == S_COEF_REF) ? P_REF_BASE + idx_reg :
      (state_reg == S_CAL)      ? P_CAL_BASE + idx_reg :
      (state_reg == S_UNUSED)   ? P_UNUSED_BASE + idx_reg :
                                  P_COEF_BASE + idx_reg;

   // Flash request: raise when idle in an access phase, drop on ack
   always_ff @(posedge clk) begin
      if (srst) begin
         req_reg   <= 1'b0;
         we_reg    <= 1'b0;
         addr_reg  <= '0;
         wdata_reg <= '0;
      end else if (req_reg) begin
         if (flash_ack) req_reg <= 1'b0;
      end else if (is_access) begin
         req_reg   <= 1'b1;
         we_reg    <= (state_reg == S_COEF_WR);
         addr_reg  <= addr_next;
         wdata_reg <= ref_reg;
      end
   end

   // Word index within the current area
   always_ff @(posedge clk) begin
      if (srst) begin
         idx_reg <= '0;
      end else if (state_reg == S_PROG_END || state_reg == S_CAL_END) begin
         idx_reg <= '0;
      end else if (got && state_reg != S_COEF_REF &&
                   !(state_reg == S_COEF_CUR && flash_rdata != ref_reg)) begin
         idx_reg <= (state_next != state_reg &&
                     state_next != S_COEF_REF) ? '0 : idx_inc;
      end
   end

   // Failure flags, each set once and held until reset
   always_ff @(posedge clk) begin
      if (srst) begin
         state_reg     <= S_PROG;
         ref_reg       <= '0;
         prog_bad_reg  <= 1'b0;
         cal_bad_reg   <= 1'b0;
         coef_bad_reg  <= 1'b0;
         blank_bad_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         if (got && state_reg == S_COEF_REF) ref_reg <= flash_rdata;
         if (state_reg == S_PROG_END && !s.zero) prog_bad_reg <= 1'b1;
         if (state_reg == S_CAL_END && !s.zero) cal_bad_reg <= 1'b1;
         if (got && state_reg == S_COEF_CUR && flash_rdata != ref_reg) begin
            coef_bad_reg <= 1'b1;
         end
         if (got && state_reg == S_UNUSED && flash_rdata != '1) begin
            blank_bad_reg <= 1'b1;
         end
      end
   end

   // Priority encoder for the reported failure
   assign any_err = prog_bad_reg | cal_bad_reg | coef_bad_reg |
                    blank_bad_reg;
   assign code_next = prog_bad_reg ? CODE_PROG :
                      cal_bad_reg  ? CODE_CAL :
                      coef_bad_reg ? CODE_COEF : CODE_UNUSED;

   // Result latched once at the end of the scan, fixed until reset
   always_ff @(posedge clk) begin
      if (srst) begin
         done_reg <= 1'b0;
         err_reg  <= 1'b0;
         code_reg <= CODE_UNUSED;
      end else if (state_reg == S_DONE && !done_reg) begin
         done_reg <= 1'b1;
         err_reg  <= any_err;
         code_reg <= code_next;
      end
   end

   // Packet status byte; data keeps flowing with errors shown
   logic [7:0] status_next;
   assign status_next[ST_LSB +: 2]  = meas_lsbs;
   assign status_next[ST_ZERO]      = 1'b0;
   assign status_next[ST_ERR]       = err_reg;
   assign status_next[ST_AUX]       = aux_flag;
   assign status_next[ST_CODE +: 2] = err_reg ? code_reg : mode_reg;
   assign status_next[ST_SAT]       = saturated;

   always_ff @(posedge clk) begin
      if (srst) begin
         status_reg <= STATUS_RESET;
      end else begin
         status_reg <= status_next;
      end
   end

   // APB decode
   logic       setup, wr_en;
   logic       hit_res, hit_sts, hit_clr, hit_en, hit_mode, hit_any;
   logic [31:0] rd_mux;

   assign setup    = psel & ~penable;
   assign wr_en    = psel & penable & pready_reg & pwrite;
   assign hit_res  = (paddr == RESULT_OFS);
   assign hit_sts  = (paddr == IRQ_STS_OFS);
   assign hit_clr  = (paddr == IRQ_CLR_OFS);
   assign hit_en   = (paddr == IRQ_EN_OFS);
   assign hit_mode = (paddr == MODE_OFS);
   assign hit_any  = hit_res | hit_sts | hit_clr | hit_en | hit_mode;

   always_comb begin
      rd_mux = '0;
      if (hit_res) begin
         rd_mux = {24'h000000, blank_bad_reg, coef_bad_reg, cal_bad_reg,
                   prog_bad_reg, code_reg, err_reg, done_reg};
      end else if (hit_sts) begin
         rd_mux = {{(32-IRQ_W){1'b0}}, irq_sts_reg};
      end else if (hit_en) begin
         rd_mux = {{(32-IRQ_W){1'b0}}, irq_en_reg};
      end else if (hit_mode) begin
         rd_mux = {30'h00000000, mode_reg};
      end
   end

   // No wait state: answer registered during the setup cycle
   always_ff @(posedge clk) begin
      if (srst) begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg  <= '0;
      end else begin
         pready_reg  <= setup;
         pslverr_reg <= setup & ~hit_any;
         prdata_reg  <= (setup & ~pwrite) ? rd_mux : '0;
      end
   end

   // Writable controls; mode bits show when no error is latched
   always_ff @(posedge clk) begin
      if (srst) begin
         mode_reg   <= MODE_RESET;
         irq_en_reg <= '0;
      end else if (wr_en) begin
         if (hit_mode) mode_reg <= pwdata[1:0];
         if (hit_en) irq_en_reg <= pwdata[IRQ_W-1:0];
      end
   end

   // Sticky events; a new event outranks a clear in the same cycle
   logic [IRQ_W-1:0] irq_set, irq_clr;
   logic             fin;
   assign fin = (state_reg == S_DONE) & ~done_reg;
   assign irq_set[IRQ_DONE] = fin;
   assign irq_set[IRQ_ERR]  = fin & any_err;
   assign irq_set[IRQ_FIX]  = got & (state_reg == S_COEF_WR);
   assign irq_clr = (wr_en & hit_clr) ? pwdata[IRQ_W-1:0] : '0;

   always_ff @(posedge clk) begin
      if (srst) begin
         irq_sts_reg <= '0;
         irq_reg     <= 1'b0;
      end else begin
         irq_sts_reg <= (irq_sts_reg & ~irq_clr) | irq_set;
         irq_reg     <= |(((irq_sts_reg & ~irq_clr) | irq_set) & irq_en_reg);
      end
   end

   assign prdata             = prdata_reg;
   assign pready             = pready_reg;
   assign pslverr            = pslverr_reg;
   assign irq                = irq_reg;
   assign flash_req          = req_reg;
   assign flash_we           = we_reg;
   assign flash_addr         = addr_reg;
   assign flash_wdata        = wdata_reg;
   assign packet_status_byte = status_reg;
   assign tx_enable          = done_reg;
endmodule : flash_startup_check

// [test/flash_startup_check_sva.sv]
`timescale 1ns/100ps
// Port-level checks for the startup flash checker
module flash_startup_check_sva
   import flash_check_pkg::*;
(
   input wire logic                               clk,
   input wire logic                               srst,
   input wire logic                               psel,
   input wire logic                               penable,
   input wire logic                               pready,
   input wire logic                               pslverr,
   input wire logic                               flash_req,
   input wire logic                               flash_we,
   input wire logic [flash_check_pkg::ADDR_W-1:0] flash_addr,
   input wire logic [flash_check_pkg::DATA_W-1:0] flash_wdata,
   input wire logic                               flash_ack,
   input wire logic [1:0]                         meas_lsbs,
   input wire logic                               saturated,
   input wire logic                               aux_flag,
   input wire logic [7:0]                         packet_status_byte,
   input wire logic                               tx_enable
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   // Flash request held whole until its ack, dropped right after
   property p_req_hold;
      flash_req && !flash_ack |=> flash_req &&
         $stable({flash_we, flash_addr, flash_wdata});
   endproperty
   a_req_hold: assert property (p_req_hold)
      else $error("flash request changed before ack");
   property p_req_drop;
      flash_req && flash_ack |=> !flash_req;
   endproperty
   a_req_drop: assert property (p_req_drop)
      else $error("flash request not dropped after ack");

   // Verification finished and latched before packets flow
   property p_tx_stays;
      tx_enable |=> tx_enable;
   endproperty
   a_tx_stays: assert property (p_tx_stays)
      else $error("transmit enable fell without reset");
   property p_done_quiet;
      tx_enable |-> !flash_req;
   endproperty
   a_done_quiet: assert property (p_done_quiet)
      else $error("flash access after result latched");
   property p_err_late;
      !tx_enable |-> !packet_status_byte[ST_ERR];
   endproperty
   a_err_late: assert property (p_err_late)
      else $error("error bit set before check done");
   property p_err_fixed;
      tx_enable && $past(tx_enable) |=> $stable(packet_status_byte[ST_ERR]);
   endproperty
   a_err_fixed: assert property (p_err_fixed)
      else $error("error bit changed after latching");

   // Measurement bits pass through one cycle late whatever the result
   property p_pass;
      !$past(srst) |-> packet_status_byte[7:6] == $past(meas_lsbs) &&
         !packet_status_byte[ST_ZERO] &&
         packet_status_byte[ST_AUX] == $past(aux_flag) &&
         packet_status_byte[ST_SAT] == $past(saturated);
   endproperty
   a_pass: assert property (p_pass)
      else $error("status byte data bits wrong");

   // Register bus answers in the first access cycle, for one cycle
   property p_ready;
      psel && !penable |=> pready ##1 !pready;
   endproperty
   a_ready: assert property (p_ready)
      else $error("bus ready not a single access pulse");
   property p_slverr;
      pslverr |-> pready;
   endproperty
   a_slverr: assert property (p_slverr)
      else $error("error response without ready");

   c_err: cover property (tx_enable && packet_status_byte[ST_ERR]);
   c_fix: cover property (flash_req && flash_ack && flash_we);
   c_slverr: cover property (pslverr);
endmodule : flash_startup_check_sva

bind flash_startup_check flash_startup_check_sva u_sva (
   .clk(clk), .srst(srst), .psel(psel), .penable(penable),
   .pready(pready), .pslverr(pslverr), .flash_req(flash_req),
   .flash_we(flash_we), .flash_addr(flash_addr),
   .flash_wdata(flash_wdata), .flash_ack(flash_ack),
   .meas_lsbs(meas_lsbs), .saturated(saturated), .aux_flag(aux_flag),
   .packet_status_byte(packet_status_byte), .tx_enable(tx_enable));

// [test/flash_word_model.sv]
`timescale 1ns/100ps
// Sixteen-word flash with prompt or slow answers; sparse map folded in
module flash_word_model
   import flash_check_pkg::*;
(
   input  wire logic                               clk,
   input  wire logic                               slow,
   input  wire logic                               req,
   input  wire logic                               we,
   input  wire logic [flash_check_pkg::ADDR_W-1:0] addr,
   input  wire logic [flash_check_pkg::DATA_W-1:0] wdata,
   output logic                                    ack,
   output logic      [flash_check_pkg::DATA_W-1:0] rdata
);
   logic [DATA_W-1:0] mem [0:15];
   logic [1:0]        wait_cnt = 2'h0;
   logic [DATA_W-1:0] data_q   = 16'h0000;
   logic [3:0]        idx;

   // Program words 0..3; upper areas two words each from index 4
   assign idx = addr[10] ? 4'h4 + {1'b0, addr[7:6], addr[0]} : addr[3:0];

   // Read data valid only with ack; toggles otherwise so no stale hit
   always @(posedge clk) begin
      ack <= 1'b0;
      wait_cnt <= (req && !ack) ? wait_cnt + 2'h1 : 2'h0;
      data_q <= ~data_q;
      if (req && !ack && wait_cnt >= (slow ? 2'h2 : 2'h0)) begin
         ack <= 1'b1;
         if (we) mem[idx] <= wdata;
         else data_q <= mem[idx];
      end
   end
   assign rdata = data_q;
endmodule : flash_word_model

// [test/flash_startup_check_test.sv]
`timescale 1ns/100ps
// One boot per flash image, result read back over the bus
module flash_startup_check_test;
   import flash_check_pkg::*;
   logic        clk = 1'b0, srst = 1'b1, slow = 1'b0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic        pready, pslverr, irq, flash_req, flash_we, flash_ack;
   logic [15:0] flash_addr, flash_wdata, flash_rdata;
   logic [1:0]  meas_lsbs = 2'h0, mode_now = 2'h0;
   logic        saturated = 1'b0, aux_flag = 1'b0, tx_enable;
   logic [7:0]  packet_status_byte;
   int          mismatches = 0, samples_checked = 0;

   always #10 clk = ~clk;

   // Short areas at the default bases, reference moved to word 2, keep each boot short
   flash_startup_check #(.P_PROG_LEN(16'h0004), .P_REF_BASE(16'h0002),
      .P_COEF_LEN(16'h0002), .P_CAL_LEN(16'h0002),
      .P_UNUSED_LEN(16'h0002)) u_flash_startup_check (
      .clk(clk), .srst(srst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .irq(irq),
      .flash_req(flash_req), .flash_we(flash_we),
      .flash_addr(flash_addr), .flash_wdata(flash_wdata),
      .flash_ack(flash_ack), .flash_rdata(flash_rdata),
      .meas_lsbs(meas_lsbs), .saturated(saturated), .aux_flag(aux_flag),
      .packet_status_byte(packet_status_byte), .tx_enable(tx_enable));
   flash_word_model u_flash_word_model (.clk(clk), .slow(slow),
      .req(flash_req), .we(flash_we), .addr(flash_addr),
      .wdata(flash_wdata), .ack(flash_ack), .rdata(flash_rdata));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   // Setup then access, held until ready is sampled high
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // Only the watchdog ends a wait for ready
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Program sums to zero; cal sums to zero; reference is words 2..3
   task automatic load(input logic pb, cb, lb, ub);
      u_flash_word_model.mem[0] = pb ? 16'h1112 : 16'h1111;
      u_flash_word_model.mem[1] = 16'hed8a;
      u_flash_word_model.mem[2] = 16'h00aa;
      u_flash_word_model.mem[3] = 16'h00bb;
      u_flash_word_model.mem[4] = 16'h00aa;
      u_flash_word_model.mem[5] = cb ? 16'h0000 : 16'h00bb;
      u_flash_word_model.mem[6] = 16'h1234;
      u_flash_word_model.mem[7] = lb ? 16'hedcd : 16'hedcc;
      u_flash_word_model.mem[8] = 16'hffff;
      u_flash_word_model.mem[9] = ub ? 16'hfffe : 16'hffff;
   endtask : load

   task automatic boot();
      int n = 0;
      srst <= 1'b1;
      mode_now = MODE_RESET;
      repeat (12) @(posedge clk);
      srst <= 1'b0;
      do begin
         @(posedge clk);
         n++;
      end while (tx_enable !== 1'b1 && n < 2000);
      chk({31'h0, tx_enable}, 32'h1);
   endtask : boot

   // Result register and the status byte that packets carry
   task automatic verify(input logic [7:0] res);
      logic [31:0] r;
      logic        e;
      apb(1'b0, RESULT_OFS, 32'h0, r, e);
      chk(r, {24'h0, res});
      @(posedge clk);
      chk({24'h0, packet_status_byte},
          {24'h0, meas_lsbs, 1'b0, res[1], aux_flag,
           res[1] ? res[3:2] : mode_now, saturated});
   endtask : verify

   task automatic s_clean();
      logic [31:0] r;
      logic        e;
      load(0, 0, 0, 0);
      meas_lsbs <= 2'h1;
      aux_flag <= 1'b1;
      boot();
      verify(8'h01);
      apb(1'b1, MODE_OFS, 32'h2, r, e);
      mode_now = 2'h2;
      verify(8'h01);
      apb(1'b0, IRQ_STS_OFS, 32'h0, r, e);
      chk(r, 32'h1);
      chk({31'h0, irq}, 32'h0);
      apb(1'b1, IRQ_EN_OFS, 32'h7, r, e);
      repeat (3) @(posedge clk);
      chk({31'h0, irq}, 32'h1);
      apb(1'b1, IRQ_CLR_OFS, 32'h7, r, e);
      repeat (3) @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      apb(1'b0, 12'h020, 32'h0, r, e);
      chk({r[30:0], e}, 32'h1);
      $display("test clean done");
   endtask : s_clean

   // Mismatch rewritten, so the next boot is clean
   task automatic s_coef();
      logic [31:0] r;
      logic        e;
      load(0, 1, 0, 0);
      slow <= 1'b1;
      meas_lsbs <= 2'h2;
      saturated <= 1'b1;
      boot();
      verify(8'h4b);
      // Done, error and rewrite events all recorded
      apb(1'b0, IRQ_STS_OFS, 32'h0, r, e);
      chk(r, 32'h7);
      chk({16'h0, u_flash_word_model.mem[5]}, 32'hbb);
      boot();
      verify(8'h01);
      $display("test coef done");
   endtask : s_coef

   task automatic s_cal();
      load(0, 1, 1, 0);
      boot();
      verify(8'h6f);
      chk({16'h0, u_flash_word_model.mem[5]}, 32'hbb);
      $display("test cal done");
   endtask : s_cal

   task automatic s_prog();
      logic [31:0] r;
      logic        e;
      load(1, 1, 0, 0);
      slow <= 1'b0;
      boot();
      verify(8'h17);
      // No rewrite event when the program sum failed
      apb(1'b0, IRQ_STS_OFS, 32'h0, r, e);
      chk(r, 32'h3);
      chk({16'h0, u_flash_word_model.mem[5]}, 32'h0);
      $display("test prog done");
   endtask : s_prog

   // Lowest code 00; measurement bits keep flowing after the error
   task automatic s_unused();
      load(0, 0, 0, 1);
      boot();
      verify(8'h83);
      meas_lsbs <= 2'h3;
      aux_flag <= 1'b0;
      repeat (2) @(posedge clk);
      verify(8'h83);
      $display("test unused done");
   endtask : s_unused

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : tally_and_finish

   // Whole run needs well under a thousand cycles per boot
   initial begin
      #400000;
      mismatches++;
      tally_and_finish();
   end

   initial begin
      s_clean();
      s_coef();
      s_cal();
      s_prog();
      s_unused();
      tally_and_finish();
   end
endmodule : flash_startup_check_test
